// *** hdl/bam_pkg.sv ***
// Constants, register map and types for the bank address mapper.
// Assumes one clock domain and a plain byte-addressed register port.
//
// Notes on behaviour
// - Each local area's logical range is fixed; no register moves it.
// - With under 16 Mbytes unexpanded, reset leaves every address untranslated.
// - Area 0 register: enable bit 7, bank bits 2..0 drive address 22..20.
// - Area 1 register: enable bit 7, bank bits 2..0 drive address 23..21.
// - Area 2 register: enable bit 7, bank bits 2..0 drive address 23..21.
// - Area 3 register: enable bit 7, bank bits 4..0 drive address 26..22.
// - Enabled area hit drives bank number plus in-area offset onto the pins.
// - Area 0 decodes upper byte 10..1F hex, 1-Mbyte banks.
// - Area 1 decodes upper byte 40..5F hex, 2-Mbyte banks.
// - Area 2 decodes upper byte C0..DF hex; E00000..FFFFFF stays untranslated.
// - Area 3 decodes upper byte 80..BF hex, 4-Mbyte banks.
package bam_pkg;

    localparam int LA_W     = 24;
    localparam int PA_W     = 27;
    localparam int REG_AW   = 9;
    localparam int REG_DW   = 8;
    localparam int BANK_W   = 5;
    localparam int AREAS    = 4;
    localparam int DATA_CS  = 4;

    // Register offsets
    localparam logic [REG_AW-1:0] OFF_AREA0  = 9'h1D0;
    localparam logic [REG_AW-1:0] OFF_AREA1  = 9'h1D1;
    localparam logic [REG_AW-1:0] OFF_AREA2  = 9'h1D2;
    localparam logic [REG_AW-1:0] OFF_AREA3  = 9'h1D3;
    localparam logic [REG_AW-1:0] OFF_STATUS = 9'h1D4;

    // Field layout and reset values
    localparam int                ENABLE_BIT = 7;
    localparam logic [BANK_W-1:0] BANK3_MASK = 5'h07;
    localparam logic [BANK_W-1:0] BANK5_MASK = 5'h1F;
    localparam logic [REG_DW-1:0] REG_RESET  = 8'h00;

    // Fixed logical area tags on the upper address bits
    localparam logic [3:0] AREA0_TAG   = 4'h1;
    localparam logic [2:0] AREA1_TAG   = 3'h2;
    localparam logic [2:0] AREA2_TAG   = 3'h6;
    localparam logic [1:0] AREA3_TAG   = 2'h2;
    localparam int         AREA0_SHIFT = 20;
    localparam int         AREA1_SHIFT = 21;
    localparam int         AREA2_SHIFT = 21;
    localparam int         AREA3_SHIFT = 22;

    // Area 3 bank bits that choose the data chip select
    localparam int CS_SEL_LSB = 3;

    typedef enum logic [2:0] {
        AREA_NONE = 3'b000,
        AREA_0    = 3'b001,
        AREA_1    = 3'b010,
        AREA_2    = 3'b011,
        AREA_3    = 3'b100
    } bam_area_t;

endpackage : bam_pkg

// *** hdl/bam_mapper.sv ***
// Bank address mapper: four bank-select registers and the logical to
// physical address translation that drives the external address pins.
// Assumes the CPU logical address comes from logic on the same clock.
//
// Design decision made here: strobed register access.
module bam_mapper (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Register port
    input  wire logic [bam_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [bam_pkg::REG_DW-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [bam_pkg::REG_DW-1:0]  reg_rdata,
    // CPU logical address
    input  wire logic [bam_pkg::LA_W-1:0]    cpu_addr,
    // External address pins
    output logic      [bam_pkg::LA_W-1:0]    ext_addr,
    output logic                             extended_addr_bit24,
    output logic                             extended_addr_bit25,
    output logic                             extended_addr_bit26,
    // Area 3 data memory chip selects
    output logic      [bam_pkg::DATA_CS-1:0] data_cs_n,
    // Translation status
    output bam_pkg::bam_area_t               mapped_area
);

    // Bank number in place, offset bits kept below the shift
    function automatic logic [bam_pkg::PA_W-1:0] bam_splice(
        input logic [bam_pkg::BANK_W-1:0] bank,
        input logic [bam_pkg::LA_W-1:0]   la,
        input int                         shift
    );
        logic [bam_pkg::PA_W-1:0] base;
        logic [bam_pkg::PA_W-1:0] mask;
        base = {22'h000000, bank} << shift;
        mask = (27'h0000001 << shift) - 27'h0000001;
        return base | ({3'h0, la} & mask);
    endfunction : bam_splice

    // Register state
    logic [bam_pkg::AREAS-1:0]  enable_q;
    logic [bam_pkg::BANK_W-1:0] bank_q [bam_pkg::AREAS];
    logic [bam_pkg::REG_DW-1:0] rdata_q;

    // Output state
    logic [bam_pkg::PA_W-1:0]    phys_q;
    logic [bam_pkg::PA_W-1:0]    phys_d;
    logic [bam_pkg::DATA_CS-1:0] cs_n_q;
    logic [bam_pkg::DATA_CS-1:0] cs_n_d;
    bam_pkg::bam_area_t          area_q;
    bam_pkg::bam_area_t          area_d;

    // Register port decode
    wire logic                        sel_area0  = (reg_addr == bam_pkg::OFF_AREA0);
    wire logic                        sel_area1  = (reg_addr == bam_pkg::OFF_AREA1);
    wire logic                        sel_area2  = (reg_addr == bam_pkg::OFF_AREA2);
    wire logic                        sel_area3  = (reg_addr == bam_pkg::OFF_AREA3);
    wire logic                        sel_status = (reg_addr == bam_pkg::OFF_STATUS);
    wire logic [bam_pkg::AREAS-1:0]   sel_area   = {sel_area3, sel_area2,
                                                    sel_area1, sel_area0};
    wire logic [bam_pkg::BANK_W-1:0]  wr_bank    = reg_wdata[bam_pkg::BANK_W-1:0];
    wire logic                        wr_enable  = reg_wdata[bam_pkg::ENABLE_BIT];

    // Areas 0..2 hold three bank bits; area 3 holds five
    wire logic [bam_pkg::BANK_W-1:0]  bank_mask [bam_pkg::AREAS] = '{
        bam_pkg::BANK3_MASK, bam_pkg::BANK3_MASK,
        bam_pkg::BANK3_MASK, bam_pkg::BANK5_MASK
    };

    // Read mux; unused and unmapped bits read as zero
    logic [bam_pkg::REG_DW-1:0] rd_area [bam_pkg::AREAS];
    logic [bam_pkg::REG_DW-1:0] rd_mux;

    always_comb begin
        for (int i = 0; i < bam_pkg::AREAS; i++) begin
            rd_area[i] = {enable_q[i], 2'h0, bank_q[i]};
        end
        rd_mux = 8'h00;
        for (int i = 0; i < bam_pkg::AREAS; i++) begin
            if (sel_area[i]) begin
                rd_mux = rd_area[i];
            end
        end
        if (sel_status) begin
            rd_mux = {5'h00, area_q};
        end
    end

    // Bank registers; all clear on reset so nothing translates until set
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < bam_pkg::AREAS; i++) begin
                enable_q[i] <= bam_pkg::REG_RESET[bam_pkg::ENABLE_BIT];
                bank_q[i]   <= bam_pkg::REG_RESET[bam_pkg::BANK_W-1:0];
            end
        end else if (reg_wr) begin
            for (int i = 0; i < bam_pkg::AREAS; i++) begin
                if (sel_area[i]) begin
                    enable_q[i] <= wr_enable;
                    bank_q[i]   <= wr_bank & bank_mask[i];
                end
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Fixed area decode; no register touches these comparisons
    wire logic hit_area0 = (cpu_addr[23:20] == bam_pkg::AREA0_TAG);
    wire logic hit_area1 = (cpu_addr[23:21] == bam_pkg::AREA1_TAG);
    wire logic hit_area2 = (cpu_addr[23:21] == bam_pkg::AREA2_TAG);
    wire logic hit_area3 = (cpu_addr[23:22] == bam_pkg::AREA3_TAG);

    // Translated candidates for each area
    wire logic [bam_pkg::PA_W-1:0] xl_area0 =
        bam_splice(bank_q[0], cpu_addr, bam_pkg::AREA0_SHIFT);
    wire logic [bam_pkg::PA_W-1:0] xl_area1 =
        bam_splice(bank_q[1], cpu_addr, bam_pkg::AREA1_SHIFT);
    wire logic [bam_pkg::PA_W-1:0] xl_area2 =
        bam_splice(bank_q[2], cpu_addr, bam_pkg::AREA2_SHIFT);
    wire logic [bam_pkg::PA_W-1:0] xl_area3 =
        bam_splice(bank_q[3], cpu_addr, bam_pkg::AREA3_SHIFT);
    wire logic [bam_pkg::PA_W-1:0] passthru = {3'h0, cpu_addr};

    // Area 3 chip select from bank number in groups of eight
    wire logic [1:0] cs_index = bank_q[3][bam_pkg::BANK_W-1:bam_pkg::CS_SEL_LSB];

    // Areas never overlap, so order here is only for form
    always_comb begin
        phys_d = passthru;
        cs_n_d = '1;
        area_d = bam_pkg::AREA_NONE;
        if (hit_area0 && enable_q[0]) begin
            phys_d = xl_area0;
            area_d = bam_pkg::AREA_0;
        end else if (hit_area1 && enable_q[1]) begin
            phys_d = xl_area1;
            area_d = bam_pkg::AREA_1;
        end else if (hit_area2 && enable_q[2]) begin
            phys_d = xl_area2;
            area_d = bam_pkg::AREA_2;
        end else if (hit_area3 && enable_q[3]) begin
            phys_d = xl_area3;
            area_d = bam_pkg::AREA_3;
            cs_n_d[cs_index] = 1'b0;
        end
    end

    // Pins come from flops: one cycle from logical address to pins
    always_ff @(posedge clk) begin
        if (rst) begin
            phys_q <= 27'h0000000;
            cs_n_q <= '1;
            area_q <= bam_pkg::AREA_NONE;
        end else begin
            phys_q <= phys_d;
            cs_n_q <= cs_n_d;
            area_q <= area_d;
        end
    end

    assign reg_rdata           = rdata_q;
    assign ext_addr            = phys_q[bam_pkg::LA_W-1:0];
    assign extended_addr_bit24 = phys_q[24];
    assign extended_addr_bit25 = phys_q[25];
    assign extended_addr_bit26 = phys_q[26];
    assign data_cs_n           = cs_n_q;
    assign mapped_area         = area_q;

endmodule : bam_mapper

// *** dv/bam_checker.sv ***
// Port checker for the bank address mapper.
// Assumes binding to bam_mapper with its registered one-cycle translation.
module bam_checker (
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // Register and address ports
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    input wire logic [23:0]        cpu_addr,
    input wire logic [23:0]        ext_addr,
    input wire logic               extended_addr_bit24,
    input wire logic               extended_addr_bit25,
    input wire logic               extended_addr_bit26,
    input wire logic [3:0]         data_cs_n,
    input wire bam_pkg::bam_area_t mapped_area
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire [26:0] phys = {extended_addr_bit26, extended_addr_bit25, extended_addr_bit24, ext_addr};
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    a_cs_idle_high: assert property (mapped_area != bam_pkg::AREA_3 |-> data_cs_n == 4'hF)
        else $error("data select active outside area 3");
    a_cs_group_pick: assert property (mapped_area == bam_pkg::AREA_3 |->
        data_cs_n == ~(4'h1 << phys[26:25])) else $error("wrong data select group");
    a_pass_thru_addr: assert property (!$past(rst) && mapped_area == bam_pkg::AREA_NONE |->
        phys == {3'h0, $past(cpu_addr)}) else $error("untranslated address changed");
    a_area0_map: assert property (mapped_area == bam_pkg::AREA_0 |->
        $past(cpu_addr[23:20]) == 4'h1 && phys[26:23] == 4'h0
        && phys[19:0] == $past(cpu_addr[19:0])) else $error("area 0 mapping wrong");
    a_area1_map: assert property (mapped_area == bam_pkg::AREA_1 |->
        $past(cpu_addr[23:21]) == 3'h2 && phys[26:24] == 3'h0
        && phys[20:0] == $past(cpu_addr[20:0])) else $error("area 1 mapping wrong");
    a_area2_map: assert property (mapped_area == bam_pkg::AREA_2 |->
        $past(cpu_addr[23:21]) == 3'h6 && phys[26:24] == 3'h0
        && phys[20:0] == $past(cpu_addr[20:0])) else $error("area 2 mapping wrong");
    a_area3_map: assert property (mapped_area == bam_pkg::AREA_3 |->
        $past(cpu_addr[23:22]) == 2'h2 && phys[21:0] == $past(cpu_addr[21:0]))
        else $error("area 3 mapping wrong");
    a_common_pass: assert property (!$past(rst) && $past(cpu_addr[23:21]) == 3'h7 |->
        mapped_area == bam_pkg::AREA_NONE) else $error("common region translated");
endmodule : bam_checker

bind bam_mapper bam_checker u_chk (.clk(clk), .rst(rst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .ext_addr(ext_addr),
    .extended_addr_bit24(extended_addr_bit24), .extended_addr_bit25(extended_addr_bit25),
    .extended_addr_bit26(extended_addr_bit26), .data_cs_n(data_cs_n),
    .mapped_area(mapped_area));

// *** dv/bam_mem_model.sv ***
// Data memories behind the area 3 chip selects.
// Assumes registered physical address and active-low selects.
module bam_mem_model (
    input  wire logic        clk,
    input  wire logic [26:0] phys,
    input  wire logic [3:0]  cs_n,
    output logic      [7:0]  rdata
);
    logic [7:0] last_q;
    // Released bus shows the inverse of the last byte, never a stale match
    assign rdata = (cs_n != 4'hF) ? (phys[7:0] ^ 8'hA5) : ~last_q;
    always_ff @(posedge clk) last_q <= rdata;
endmodule : bam_mem_model

// *** dv/tb.sv ***
// Self-checking bench for the bank address mapper.
// Assumes a 200 MHz clock, synchronous reset and one-cycle translation.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [8:0]  reg_addr = 9'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [23:0] cpu_addr = 24'h000000;
    logic [7:0]  reg_rdata, mem_q;
    logic [23:0] ext_addr;
    logic        extended_addr_bit24, extended_addr_bit25, extended_addr_bit26;
    logic [3:0]  data_cs_n;
    bam_pkg::bam_area_t mapped_area;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [7:0]  msk [6] = '{8'h87, 8'h87, 8'h87, 8'h9F, 8'h01, 8'h00};
    logic [4:0]  bk [4] = '{5'h05, 5'h0A, 5'h10, 5'h1D};
    logic [3:0]  csx [4] = '{4'hE, 4'hD, 4'hB, 4'h7};
    always #2.5 clk = ~clk;
    bam_mapper u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
        .ext_addr(ext_addr), .extended_addr_bit24(extended_addr_bit24),
        .extended_addr_bit25(extended_addr_bit25), .extended_addr_bit26(extended_addr_bit26),
        .data_cs_n(data_cs_n), .mapped_area(mapped_area));
    bam_mem_model u_mem (.clk(clk), .phys({extended_addr_bit26, extended_addr_bit25,
        extended_addr_bit24, ext_addr}), .cs_n(data_cs_n), .rdata(mem_q));
    task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(27'(reg_rdata), 27'(exp));
    endtask : rd
    // One address per call; the answer lands one edge after it is taken
    task automatic xl(input logic [23:0] a, input logic [26:0] p, input logic [2:0] ar,
                      input logic [3:0] cs);
        @(posedge clk);
        cpu_addr <= a;
        @(posedge clk);
        #1;
        chk({extended_addr_bit26, extended_addr_bit25, extended_addr_bit24, ext_addr}, p);
        chk(27'(mapped_area), 27'(ar));
        chk(27'(data_cs_n), 27'(cs));
        if (cs !== 4'hF) chk(27'(mem_q), 27'(p[7:0] ^ 8'hA5));
    endtask : xl
    task automatic summarize;
        $display("Errors %0d of %0d comparisons", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #100us;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(9'h1D0 + 9'(i), 8'h00);
        xl(24'h1ABCDE, 27'h01ABCDE, 3'd0, 4'hF);
        for (int i = 0; i < 6; i++) wr(9'h1D0 + 9'(i), 8'hFF);
        for (int i = 0; i < 6; i++) rd(9'h1D0 + 9'(i), msk[i]);
        wr(9'h1D0, 8'h85);
        xl(24'h1ABCDE, 27'h05ABCDE, 3'd1, 4'hF);
        wr(9'h1D1, 8'h83);
        xl(24'h4ABCDE, 27'h06ABCDE, 3'd2, 4'hF);
        xl(24'h5FFFFF, 27'h07FFFFF, 3'd2, 4'hF);
        wr(9'h1D2, 8'h81);
        xl(24'hC01234, 27'h0201234, 3'd3, 4'hF);
        xl(24'hE00000, 27'h0E00000, 3'd0, 4'hF);
        for (int i = 0; i < 4; i++) begin
            wr(9'h1D3, 8'h80 | 8'(bk[i]));
            xl(24'hBF2345, {bk[i], 22'h3F2345}, 3'd4, csx[i]);
        end
        wr(9'h1D0, 8'h05);
        xl(24'h1ABCDE, 27'h01ABCDE, 3'd0, 4'hF);
        xl(24'h3FFFFF, 27'h03FFFFF, 3'd0, 4'hF);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(9'h1D1, 8'h00);
        xl(24'h4ABCDE, 27'h04ABCDE, 3'd0, 4'hF);
        summarize();
    end
endmodule : tb
